// [rtl/rdm_pkg.sv]
// Constants and types shared by both ends of the relay-driver mode link.
// Assumes a 100 MHz system clock and a 16-bit SPI frame, mode 0.
package rdm_pkg;
   localparam int unsigned CLK_MHZ         = 100;
   localparam int unsigned WAKE_SETTLE_US  = 200;
   localparam int unsigned WAKE_SETTLE_CYC = WAKE_SETTLE_US * CLK_MHZ;
   localparam int unsigned CNT_W           = 16;
   localparam int unsigned FRAME_W         = 16;
   localparam logic [3:0]  SCK_HALF_CYC    = 4'h8;
   // Frame layout
   localparam int unsigned FR_KIND_HI      = 15;
   localparam int unsigned FR_KIND_LO      = 14;
   localparam logic [1:0]  KIND_READ       = 2'h0;
   localparam logic [1:0]  KIND_OUT        = 2'h1;
   localparam logic [1:0]  KIND_CTRL       = 2'h3;
   localparam int unsigned FR_WAKE         = 0;
   localparam int unsigned FR_STANDBY      = 1;
   localparam int unsigned FR_SOFT_RST     = 2;
   localparam int unsigned FR_ERR          = 15;
   localparam int unsigned FR_LIMP         = 14;
   localparam logic [7:0]  OUT_RESET       = 8'h00;
   localparam int unsigned LIMP_CH_A       = 4;
   localparam int unsigned LIMP_CH_B       = 5;
   // Host registers
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_TX          = 4'h4;
   localparam logic [3:0]  REG_RX          = 4'h8;
   localparam logic [3:0]  REG_STAT        = 4'hc;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [3:0] {
      MODE_SLEEP  = 4'h1,
      MODE_WAKING = 4'h2,
      MODE_ON     = 4'h4,
      MODE_LIMP   = 4'h8
   } rdm_mode_t;

   typedef enum logic [3:0] {
      HST_IDLE   = 4'h1,
      HST_RUN    = 4'h2,
      HST_TRAIL  = 4'h4,
      HST_SETTLE = 4'h8
   } rdm_hst_t;
endpackage

// [rtl/rdm_link_if.sv]
// SPI link between host controller and relay driver.
// Bench adds nothing; the serial output line floats high when not driven.
`timescale 1ns/100ps
interface rdm_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so;
   logic so_oe;
   logic so_line;

   // Pull-up on the shared serial output line
   assign so_line = so_oe ? so : 1'b1;

   modport dev  (input cs_n, input sclk, input si, output so, output so_oe);
   modport host (output cs_n, output sclk, output si, input so_line);
endinterface

// [rtl/rdm_spi_shift.sv]
// Serial shifter of the relay driver: samples the link pins and shifts frames.
// Assumes mode 0 and a link clock well below a quarter of clk_i.
`timescale 1ns/100ps
module rdm_spi_shift
   import rdm_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               en_i,
   input  wire logic               cs_n_i,
   input  wire logic               sclk_i,
   input  wire logic               si_i,
   input  wire logic [FRAME_W-1:0] resp_i,
   output logic                    so_o,
   output logic                    so_oe_o,
   output logic                    done_o,
   output logic                    bad_o,
   output logic [FRAME_W-1:0]      frame_o
);
   typedef struct packed {
      logic [2:0]         meta;
      logic [2:0]         sync;
      logic [2:0]         last;
      logic               sin;
      logic [FRAME_W-1:0] sh;
      logic [4:0]         cnt;
      logic               so;
      logic               oe;
      logic               done;
      logic               bad;
      logic [FRAME_W-1:0] frame;
   } rdm_sh_t;

   rdm_sh_t s_q, s_d;
   logic cs_fall, cs_rise, rise, fall, active;

   always_comb begin
      s_d      = s_q;
      s_d.meta = {cs_n_i, sclk_i, si_i};
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
      s_d.done = 1'b0;
      s_d.bad  = 1'b0;
      active   = !s_q.sync[2];
      cs_fall  = s_q.last[2] && !s_q.sync[2];
      cs_rise  = !s_q.last[2] && s_q.sync[2];
      rise     = active && !s_q.last[1] && s_q.sync[1];
      fall     = active && s_q.last[1] && !s_q.sync[1];
      if (!en_i) begin
         // Without logic supply the link is dead
         s_d.oe  = 1'b0;
         s_d.cnt = 5'h00;
      end else begin
         if (cs_fall) begin
            s_d.sh  = resp_i;
            s_d.so  = resp_i[FRAME_W-1];
            s_d.oe  = 1'b1;
            s_d.cnt = 5'h00;
         end
         if (rise) begin
            s_d.sin = s_q.sync[0];
         end
         if (fall) begin
            s_d.sh  = {s_q.sh[FRAME_W-2:0], s_q.sin};
            s_d.so  = s_q.sh[FRAME_W-2];
            s_d.cnt = s_q.cnt + 5'h01;
         end
         if (cs_rise) begin
            s_d.oe    = 1'b0;
            s_d.frame = s_q.sh;
            s_d.done  = (s_q.cnt == 5'(FRAME_W));
            s_d.bad   = (s_q.cnt != 5'(FRAME_W));
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q      <= '0;
         s_q.meta <= 3'h7;
         s_q.sync <= 3'h7;
         s_q.last <= 3'h7;
      end else begin
         s_q <= s_d;
      end
   end

   assign so_o    = s_q.so;
   assign so_oe_o = s_q.oe;
   assign done_o  = s_q.done;
   assign bad_o   = s_q.bad;
   assign frame_o = s_q.frame;
endmodule // rdm_spi_shift

// [rtl/rdm_dev.sv]
// Relay-driver end: operating modes, reset sources and command acceptance.
// Assumes supply-good flags, limp pin and input pins arrive asynchronously.
`timescale 1ns/100ps
module rdm_dev
   import rdm_pkg::*;
#(
   parameter int unsigned WAKE_CYC = WAKE_SETTLE_CYC
)(
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   rdm_link_if.dev     link,
   input  wire logic   vdd_ok_i,
   input  wire logic   vbb_ok_i,
   input  wire logic   fallback_drive_input_i,
   input  wire logic   in1_i,
   input  wire logic   in2_i,
   output logic [7:0]  ch_o,
   output logic [3:0]  mode_o,
   output logic        frame_error_flag_o,
   output logic        cmd_dropped_o
);
   typedef struct packed {
      logic [4:0]     meta;
      logic [4:0]     sync;
      rdm_mode_t      mode;
      logic [CNT_W-1:0] cnt;
      logic [7:0]     out_reg;
      logic [7:0]     ch;
      logic           err;
      logic           dropped;
   } rdm_dev_t;

   rdm_dev_t s_q, s_d;
   logic               vdd_ok, vbb_ok, limp, uv;
   logic               done, bad, so, so_oe;
   logic [FRAME_W-1:0] frame, resp;

   assign vdd_ok = s_q.sync[4];
   assign vbb_ok = s_q.sync[3];
   assign limp   = s_q.sync[2];

   // Diagnostic answer, also valid during vbb undervoltage reset (link is dead while vdd_ok is low)
   assign resp = {s_q.err, (s_q.mode == MODE_LIMP), (s_q.mode == MODE_ON),
                  (s_q.mode == MODE_WAKING), 4'h0, s_q.out_reg};

   rdm_spi_shift u_shift (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (vdd_ok),
      .cs_n_i  (link.cs_n),
      .sclk_i  (link.sclk),
      .si_i    (link.si),
      .resp_i  (resp),
      .so_o    (so),
      .so_oe_o (so_oe),
      .done_o  (done),
      .bad_o   (bad),
      .frame_o (frame)
   );

   assign link.so    = so;
   assign link.so_oe = so_oe;

   always_comb begin
      s_d         = s_q;
      s_d.meta    = {vdd_ok_i, vbb_ok_i, fallback_drive_input_i, in1_i, in2_i};
      s_d.sync    = s_q.meta;
      s_d.dropped = 1'b0;
      uv          = !vdd_ok || !vbb_ok;
      // Frame just shifted out carried the flag; error events override
      if (done) begin
         s_d.err = 1'b0;
      end
      if (bad) begin
         s_d.err = 1'b1;
      end
      if (uv) begin
         s_d.mode    = MODE_SLEEP;
         s_d.out_reg = OUT_RESET;
         s_d.err     = 1'b1;
         s_d.cnt     = '0;
      end else if (limp) begin
         s_d.mode    = MODE_LIMP;
         s_d.out_reg = OUT_RESET;
         s_d.cnt     = '0;
         s_d.dropped = done && (frame[FR_KIND_HI:FR_KIND_LO] != KIND_READ);
      end else if (s_q.mode == MODE_LIMP) begin
         s_d.mode    = MODE_SLEEP;
         s_d.out_reg = OUT_RESET;
      end else begin
         if (s_q.mode == MODE_WAKING) begin
            if (s_q.cnt == CNT_W'(WAKE_CYC - 1)) begin
               s_d.mode = MODE_ON;
               s_d.cnt  = '0;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
            s_d.dropped = done;
         end else if (done) begin
            case (frame[FR_KIND_HI:FR_KIND_LO])
               KIND_CTRL: begin
                  if (frame[FR_SOFT_RST]) begin
                     s_d.mode    = MODE_SLEEP;
                     s_d.out_reg = OUT_RESET;
                     s_d.err     = 1'b1;
                  end else if (frame[FR_WAKE] && s_q.mode == MODE_SLEEP) begin
                     s_d.mode = MODE_WAKING;
                     s_d.cnt  = '0;
                  end else if (frame[FR_STANDBY] && s_q.mode == MODE_ON) begin
                     s_d.mode    = MODE_SLEEP;
                     s_d.out_reg = OUT_RESET;
                  end
               end
               KIND_OUT: begin
                  if (s_q.mode == MODE_ON) begin
                     s_d.out_reg = frame[7:0];
                  end else begin
                     s_d.dropped = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Output stage follows the mode
      case (s_d.mode)
         MODE_ON: begin
            s_d.ch = s_d.out_reg;
         end
         MODE_LIMP: begin
            s_d.ch            = 8'h00;
            s_d.ch[LIMP_CH_A] = s_q.sync[1];
            s_d.ch[LIMP_CH_B] = s_q.sync[0];
         end
         default: begin
            s_d.ch = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q      <= '0;
         s_q.mode <= MODE_SLEEP;
         s_q.err  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign ch_o               = s_q.ch;
   assign mode_o             = s_q.mode;
   assign frame_error_flag_o = s_q.err;
   assign cmd_dropped_o      = s_q.dropped;
endmodule // rdm_dev

// [rtl/rdm_host.sv]
// Host end: AXI4-Lite slave that sends one SPI frame per order.
// Assumes the device end samples the link with its own clock.
`timescale 1ns/100ps
module rdm_host
   import rdm_pkg::*;
#(
   parameter int unsigned WAKE_CYC = WAKE_SETTLE_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   rdm_link_if.host         link,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      logic               awready, wready, bvalid, arready, rvalid;
      logic [1:0]         bresp, rresp;
      logic [31:0]        rdata;
      logic               aw_have, w_have;
      logic [3:0]         awaddr;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic [FRAME_W-1:0] tx, sh, rx;
      rdm_hst_t           st;
      logic               done, cs_n, sclk, si;
      logic [4:0]         bits;
      logic [3:0]         div;
      logic [CNT_W-1:0]   cnt;
      logic [1:0]         so_meta;
   } rdm_host_t;

   rdm_host_t s_q, s_d;
   logic      so_s, busy, wake_frame;

   assign so_s = s_q.so_meta[1];
   assign busy = (s_q.st != HST_IDLE);
   assign wake_frame = (s_q.tx[FR_KIND_HI:FR_KIND_LO] == KIND_CTRL) && s_q.tx[FR_WAKE];

   always_comb begin
      s_d         = s_q;
      s_d.so_meta = {s_q.so_meta[0], link.so_line};
      // Write channel pair
      if (s_q.awready && s_axi_awvalid) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
         s_d.awready = 1'b0;
      end
      if (s_q.wready && s_axi_wvalid) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
         s_d.wready = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = RESP_OKAY;
         case (s_q.awaddr)
            REG_TX: begin
               if (s_q.wstrb[0]) s_d.tx[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.tx[15:8] = s_q.wdata[15:8];
            end
            REG_CTRL: begin
               // Start ignored while a frame or settle wait is running
               if (s_q.wstrb[0] && s_q.wdata[0] && !busy) begin
                  s_d.st   = HST_RUN;
                  s_d.cs_n = 1'b0;
                  s_d.sh   = s_q.tx;
                  s_d.si   = s_q.tx[FRAME_W-1];
                  s_d.div  = 4'h0;
                  s_d.bits = 5'h00;
                  s_d.done = 1'b0;
               end
            end
            REG_RX, REG_STAT: begin
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end
      // Read channel
      if (s_q.arready && s_axi_arvalid) begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: s_d.rdata = 32'h0000_0000;
            REG_TX:   s_d.rdata = {16'h0000, s_q.tx};
            REG_RX:   s_d.rdata = {16'h0000, s_q.rx};
            REG_STAT: s_d.rdata = {28'h0000000, s_q.st == HST_SETTLE, 1'b0, s_q.done, busy};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      // Frame sequencer
      case (s_q.st)
         HST_RUN: begin
            s_d.div = s_q.div + 4'h1;
            if (s_q.div == SCK_HALF_CYC - 4'h1) begin
               s_d.div = 4'h0;
               if (!s_q.sclk) begin
                  s_d.sclk = 1'b1;
                  s_d.rx   = {s_q.rx[FRAME_W-2:0], so_s};
                  s_d.bits = s_q.bits + 5'h01;
               end else begin
                  s_d.sclk = 1'b0;
                  s_d.sh   = {s_q.sh[FRAME_W-2:0], 1'b0};
                  s_d.si   = s_q.sh[FRAME_W-2];
                  if (s_q.bits == 5'(FRAME_W)) begin
                     s_d.st = HST_TRAIL;
                  end
               end
            end
         end
         HST_TRAIL: begin
            s_d.div = s_q.div + 4'h1;
            if (s_q.div == SCK_HALF_CYC - 4'h1) begin
               s_d.div  = 4'h0;
               s_d.cs_n = 1'b1;
               s_d.cnt  = '0;
               if (wake_frame) begin
                  s_d.st = HST_SETTLE;
               end else begin
                  s_d.st   = HST_IDLE;
                  s_d.done = 1'b1;
               end
            end
         end
         HST_SETTLE: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == CNT_W'(WAKE_CYC - 1)) begin
               s_d.st   = HST_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q         <= '0;
         s_q.st      <= HST_IDLE;
         s_q.cs_n    <= 1'b1;
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.so_meta <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.cs_n     = s_q.cs_n;
   assign link.sclk     = s_q.sclk;
   assign link.si       = s_q.si;
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
endmodule // rdm_host

// [test/rdm_link_monitor.sv]
// Checker for the relay-driver link and the device's mode outputs.
// Assumes supply and limp inputs reach the device through two-flop synchronisers.
`timescale 1ns/100ps
module rdm_link_monitor
   import rdm_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       so_oe,
   input  wire logic       vdd_ok_i,
   input  wire logic       vbb_ok_i,
   input  wire logic       fallback_drive_input_i,
   input  wire logic [7:0] ch_o,
   input  wire logic [3:0] mode_o,
   input  wire logic       frame_error_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_reset_state;
      $fell(rst_i) |-> mode_o == MODE_SLEEP && ch_o == 8'h00 && frame_error_flag_o;
   endproperty
   property p_uv_sleep;
      (!vbb_ok_i)[*5] |-> mode_o == MODE_SLEEP && ch_o == 8'h00;
   endproperty
   property p_no_so_unpowered;
      (!vdd_ok_i)[*5] |-> !so_oe;
   endproperty
   property p_limp_enter;
      (fallback_drive_input_i && vbb_ok_i && vdd_ok_i)[*5] |-> mode_o == MODE_LIMP;
   endproperty
   property p_limp_channels;
      mode_o == MODE_LIMP |-> (ch_o & 8'hcf) == 8'h00;
   endproperty
   property p_limp_exit;
      mode_o == MODE_LIMP ##1 mode_o != MODE_LIMP |-> mode_o == MODE_SLEEP;
   endproperty
   property p_sleep_off;
      mode_o == MODE_SLEEP |-> ch_o == 8'h00;
   endproperty
   property p_on_via_waking;
      $rose(mode_o == MODE_ON) |-> $past(mode_o) == MODE_WAKING;
   endproperty
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   property p_deselect_quiet;
      cs_n[*6] |-> !so_oe;
   endproperty

   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
   a_uv_sleep: assert property (p_uv_sleep) else $error("undervoltage not sleep");
   a_no_so_unpowered: assert property (p_no_so_unpowered) else $error("so driven");
   a_limp_enter: assert property (p_limp_enter) else $error("limp not entered");
   a_limp_channels: assert property (p_limp_channels) else $error("limp chans");
   a_limp_exit: assert property (p_limp_exit) else $error("limp exit not sleep");
   a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");
   a_on_via_waking: assert property (p_on_via_waking) else $error("on skipped wake");
   a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not idle low");
   a_deselect_quiet: assert property (p_deselect_quiet) else $error("so_oe idle");

   c_limp: cover property (mode_o == MODE_LIMP);
   c_on: cover property (mode_o == MODE_ON);
   c_uv: cover property ((!vbb_ok_i)[*5]);
endmodule // rdm_link_monitor

// [test/testbench.sv]
// Bench joining host and device ends; drives the host over AXI4-Lite.
// Assumes WAKE_CYC of 50 on both ends and supplies driven as plain levels.
`timescale 1ns/100ps
module testbench;
   import rdm_pkg::*;
   logic        clk_i, rst_i, vdd, vbb, fb, in1, in2;
   logic [3:0]  awaddr, araddr, wstrb, mode;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, flag, dropped;
   logic [7:0]  ch;
   logic [15:0] rx;
   int          num_errors, n_compared, n_drop;

   rdm_link_if link ();
   rdm_dev #(.WAKE_CYC(50)) i_rdm_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .vdd_ok_i(vdd), .vbb_ok_i(vbb), .fallback_drive_input_i(fb), .in1_i(in1),
      .in2_i(in2), .ch_o(ch), .mode_o(mode), .frame_error_flag_o(flag), .cmd_dropped_o(dropped));
   rdm_host #(.WAKE_CYC(50)) i_rdm_host (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rdm_link_monitor i_rdm_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
      .sclk(link.sclk), .so_oe(link.so_oe), .vdd_ok_i(vdd), .vbb_ok_i(vbb),
      .fallback_drive_input_i(fb), .ch_o(ch), .mode_o(mode), .frame_error_flag_o(flag));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Counts discarded-command pulses mid-cycle
   always @(negedge clk_i) begin
      if (rst_i) begin
         n_drop <= 0;
      end else if (dropped === 1'b1) begin
         n_drop <= n_drop + 1;
      end
   end

   task automatic stop_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic timed_out(input string what);
      $display("Error %s expected done seen timeout", what);
      num_errors++;
      stop_test();
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 100) timed_out("bvalid");
      bready <= 1'b0;
      chk("bresp", {14'h0, RESP_OKAY}, {14'h0, bresp});
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 100) timed_out("rvalid");
      d = rdata;
      rready <= 1'b0;
   endtask

   // One frame out, answer back in rx
   task automatic xfer(input logic [15:0] tx);
      logic [31:0] s;
      int          n;
      axi_wr(REG_TX, {16'h0, tx});
      axi_wr(REG_CTRL, 32'h1);
      s = 32'h1;
      for (n = 0; n < 2000 && s[0] !== 1'b0; n++) axi_rd(REG_STAT, s);
      if (n == 2000) timed_out("busy");
      axi_rd(REG_RX, s);
      rx = s[15:0];
   endtask

   // Bounded wait on mode (sel 0) or channels (sel 1)
   task automatic wait_eq(input int sel, input logic [15:0] exp);
      logic [15:0] v;
      int          n;
      for (n = 0; n < 500; n++) begin
         @(posedge clk_i);
         v = (sel == 0) ? {12'h0, mode} : {8'h0, ch};
         if (v === exp) break;
      end
      chk(sel == 0 ? "mode" : "ch", exp, v);
      if (n == 500) stop_test();
   endtask

   initial begin
      rst_i = 1'b1; vdd = 1'b1; vbb = 1'b1; fb = 1'b0; in1 = 1'b0; in2 = 1'b0;
      awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      num_errors = 0; n_compared = 0; rx = 16'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("mode", {12'h0, MODE_SLEEP}, {12'h0, mode});
      xfer(16'h0000);
      chk("rx", 16'h8000, rx);
      chk("flag", 16'h0, {15'h0, flag});
      xfer(16'hc001);
      wait_eq(0, {12'h0, MODE_ON});
      xfer(16'h40a5);
      chk("ch", 16'h00a5, {8'h0, ch});
      xfer(16'hc002);
      chk("rx", 16'h20a5, rx);
      wait_eq(0, {12'h0, MODE_SLEEP});
      xfer(16'h0000);
      chk("rx", 16'h0000, rx);
      xfer(16'h40ff);
      chk("ch", 16'h0000, {8'h0, ch});
      chk("drop", 16'h0001, 16'(n_drop));
      xfer(16'hc001);
      wait_eq(0, {12'h0, MODE_ON});
      xfer(16'h40ff);
      xfer(16'hc004);
      wait_eq(0, {12'h0, MODE_SLEEP});
      chk("ch", 16'h0000, {8'h0, ch});
      xfer(16'h0000);
      chk("rx", 16'h8000, rx);
      in1 <= 1'b1;
      fb <= 1'b1;
      wait_eq(0, {12'h0, MODE_LIMP});
      wait_eq(1, 16'h0010);
      in2 <= 1'b1;
      wait_eq(1, 16'h0030);
      xfer(16'h0000);
      chk("rx", 16'h4000, rx & 16'h7fff);
      xfer(16'hc001);
      xfer(16'h40ff);
      chk("mode", {12'h0, MODE_LIMP}, {12'h0, mode});
      chk("ch", 16'h0030, {8'h0, ch});
      chk("drop", 16'h0003, 16'(n_drop));
      fb <= 1'b0;
      wait_eq(0, {12'h0, MODE_SLEEP});
      xfer(16'hc001);
      wait_eq(0, {12'h0, MODE_ON});
      xfer(16'h4003);
      vbb <= 1'b0;
      wait_eq(0, {12'h0, MODE_SLEEP});
      chk("ch", 16'h0000, {8'h0, ch});
      chk("flag", 16'h1, {15'h0, flag});
      xfer(16'h0000);
      chk("rx", 16'h8000, rx);
      vbb <= 1'b1;
      xfer(16'hc001);
      wait_eq(0, {12'h0, MODE_ON});
      vdd <= 1'b0;
      xfer(16'h0000);
      chk("rx", 16'hffff, rx);
      vdd <= 1'b1;
      wait_eq(0, {12'h0, MODE_SLEEP});
      stop_test();
   end
endmodule // testbench
